// file: bench/dsfb_flag_bank_tb.sv
// Self-checking testbench for the status and flag register bank
module dsfb_flag_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dsfb_pkg::*;
  localparam int PC = 8;
  localparam int LIMIT = 20000;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic conv = 1'h0;
  logic hp = 1'h0;
  logic ovf = 1'h0;
  logic oc = 1'h0;
  logic [GAIN_W-1:0] ga = '0;
  logic [GAIN_W-1:0] gp = 6'h01; // Codes differ at start so the settle bit reads zero with the rest of the map
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awv = 1'h0;
  logic wv = 1'h0;
  logic bready = 1'h0;
  logic arv = 1'h0;
  logic rready = 1'h0;
  logic awrdy, wrdy, bv, arrdy, rv, irq, line;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] exp_q[$];
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Clock at 25 MHz
  initial begin
    forever #20 clk = ~clk;
  end

  dsfb_flag_bank #(.PULSE_CYCLES(PC)) u_dut (
    .REF_CLK_I(clk), .RST_B_I(rst_b), .CONV_PWR_I(conv), .HP_PWR_I(hp),
    .GAIN_APPLIED_I(ga), .GAIN_PROGRAMMED_I(gp), .CONV_OVF_I(ovf), .HP_OC_I(oc),
    .AXI_AWADDR_I(awaddr), .AXI_AWPROT_I(3'h0), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awrdy),
    .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'hF), .AXI_WVALID_I(wv), .AXI_WREADY_O(wrdy),
    .AXI_BRESP_O(bresp), .AXI_BVALID_O(bv), .AXI_BREADY_I(bready),
    .AXI_ARADDR_I(araddr), .AXI_ARPROT_I(3'h0), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arrdy),
    .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rv), .AXI_RREADY_I(rready),
    .IRQ_O(irq), .IRQ_LINE_ONE_O(line)
  );

  task automatic check(input string n, input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // A hang ends the run as a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      stop_test();
    end
  end

  // Sampled at the falling edge so the answer is settled before its handshake
  always @(negedge clk) begin
    if ((rv && rready) || (bv && bready)) begin
      if (exp_q.size() == 0) check("unexpected answer", 34'h1, 34'h0);
      else if (rv) check("read answer", {rresp, rdata}, exp_q.pop_front());
      else check("write answer", {bresp, 32'h0}, exp_q.pop_front());
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Read; the expected word is noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    logic hit;
    exp_q.push_back({r, 24'h0, d});
    araddr <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    hit = 1'h0;
    while (!hit) begin
      @(negedge clk);
      hit = arrdy;
      @(posedge clk);
    end
    arv <= 1'h0;
    hit = 1'h0;
    while (!hit) begin
      @(negedge clk);
      hit = rv;
      @(posedge clk);
    end
    // Ready stays high, so back-to-back reads never drive it twice in one step
  endtask : rd

  // Write; address and data are released each on its own handshake
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ha, hw, hb;
    exp_q.push_back({RESP_OKAY, 32'h0});
    awaddr <= a;
    awv <= 1'h1;
    wdata <= {24'h0, d};
    wv <= 1'h1;
    bready <= 1'h1;
    hb = 1'h0;
    while (!hb) begin
      @(negedge clk);
      ha = awv && awrdy;
      hw = wv && wrdy;
      hb = bv;
      @(posedge clk);
      if (ha) awv <= 1'h0;
      if (hw) wv <= 1'h0;
    end
  endtask : wr

  task automatic ev(input int j, input logic v);
    if (j == 0) ovf <= v;
    else oc <= v;
  endtask : ev

  task automatic look_irq(input logic e);
    @(negedge clk);
    check("irq level", 34'(irq), 34'(e));
    @(posedge clk);
  endtask : look_irq

  // Counts falling edges while the pulse line holds one level, capped at 40
  task automatic span(input logic lvl, output int n);
    n = 0;
    while (line === lvl && n < 40) begin
      n++;
      @(negedge clk);
    end
  endtask : span

  initial begin
    int k;
    int n;
    logic [7:0] a;
    void'($urandom(6661));
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    // Whole map reads zero after reset, holes answer with an error
    for (k = 8'h23; k <= 8'h2E; k++) rd(8'(k * 4), 8'h00);
    for (k = 0; k < 3; k++) rd(8'(8'hF0 + 4 * k), 8'h00);
    rd(8'hFC, 8'h00, RESP_SLVERR);
    rd(8'h95, 8'h00, RESP_SLVERR);
    wr(8'h8C, 8'h00);
    rd(8'h8C, 8'h00);
    $display("test reset values done");
    // Every combination of the two power states
    for (k = 0; k < 4; k++) begin
      conv <= k[0];
      hp <= k[1];
      tick(4);
      rd(8'h94, {k[0], 1'h0, k[1], 5'h00});
    end
    // Random gain codes, equal and unequal in turn
    for (k = 0; k < 6; k++) begin
      a = 8'($urandom);
      ga <= a[5:0];
      gp <= k[0] ? a[5:0] ^ 6'(1 + $urandom % 63) : a[5:0];
      tick(4);
      rd(8'h98, {3'h0, ~k[0], 4'h0});
    end
    $display("test power and gain done");
    // Overflow then over-current: live, sticky, status and level interrupt
    wr(8'hF4, 8'h03);
    for (k = 0; k < 2; k++) begin
      ev(k, 1'h1);
      tick(4);
      rd(k ? 8'hB8 : 8'hAC, 8'h80);
      rd(k ? 8'hB0 : 8'hA8, 8'h80);
      rd(k ? 8'hB0 : 8'hA8, 8'h80);
      look_irq(1'h1);
      ev(k, 1'h0);
      tick(4);
      rd(k ? 8'hB8 : 8'hAC, 8'h00);
      rd(k ? 8'hB0 : 8'hA8, 8'h80);
      rd(k ? 8'hB0 : 8'hA8, 8'h00);
      rd(8'hF0, 8'(1 << k));
      wr(8'hF0, 8'(1 << k));
      tick(2);
      look_irq(1'h0);
    end
    // Masked event still sets status but leaves the line low
    wr(8'hF4, 8'h00);
    ev(0, 1'h1);
    tick(3);
    ev(0, 1'h0);
    tick(4);
    look_irq(1'h0);
    rd(8'hF0, 8'h01);
    wr(8'hF0, 8'h01);
    rd(8'hA8, 8'h80);
    $display("test flags and interrupt done");
    // Repeating pulses on the line, stopped by the clearing read
    wr(8'hF8, 8'h0D);
    ev(1, 1'h1);
    @(negedge clk);
    span(1'h0, n);
    span(1'h1, n);
    check("pulse high", 34'(n), 34'(PC));
    span(1'h0, n);
    check("pulse gap", 34'(n), 34'(PC));
    @(posedge clk);
    ev(1, 1'h0);
    rd(8'hB0, 8'h80);
    @(negedge clk);
    span(1'h0, n);
    check("train stopped", 34'(n), 34'd40);
    @(posedge clk);
    // Single pulse mode on an overflow event: one pulse, then the line stays low
    wr(8'hF8, 8'h04);
    ev(0, 1'h1);
    @(negedge clk);
    span(1'h0, n);
    span(1'h1, n);
    check("single pulse", 34'(n), 34'(PC));
    span(1'h0, n);
    check("no repeat", 34'(n), 34'd40);
    @(posedge clk);
    ev(0, 1'h0);
    rd(8'hA8, 8'h80);
    $display("test pulse train done");
    check("pending answers", 34'(exp_q.size()), 34'h0);
    stop_test();
  end
endmodule : dsfb_flag_bank_tb

// file: design/dsfb_flag_bank.sv
// Converter and headphone status and flag register bank with AXI4-Lite slave
module dsfb_flag_bank #(
  parameter int unsigned PULSE_CYCLES = dsfb_pkg::PULSE_CYCLES_DEF
) (
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  input wire logic CONV_PWR_I,
  input wire logic HP_PWR_I,
  input wire logic [dsfb_pkg::GAIN_W-1:0] GAIN_APPLIED_I,
  input wire logic [dsfb_pkg::GAIN_W-1:0] GAIN_PROGRAMMED_I,
  input wire logic CONV_OVF_I,
  input wire logic HP_OC_I,
  input wire logic [7:0] AXI_AWADDR_I,
  input wire logic [2:0] AXI_AWPROT_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  output logic [1:0] AXI_BRESP_O,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [7:0] AXI_ARADDR_I,
  input wire logic [2:0] AXI_ARPROT_I,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  output logic IRQ_O,
  output logic IRQ_LINE_ONE_O
);
  import dsfb_pkg::*;

  // Register index of a byte address
  function automatic logic [IDX_W-1:0] to_idx(input logic [7:0] addr);
    to_idx = {2'b00, addr[7:2]};
  endfunction : to_idx

  // Mapped when word aligned and inside the flag range or the control group
  function automatic logic reg_ok(input logic [7:0] addr);
    logic [IDX_W-1:0] idx;
    idx = to_idx(addr);
    reg_ok = (addr[1:0] == 2'h0) &&
             (((idx >= IDX_RSVD_A0) && (idx <= IDX_OC_LIVE)) ||
              ((idx >= IDX_IRQ_STAT) && (idx <= IDX_LINE_CTRL)));
  endfunction : reg_ok

  // Input conditioning: every status and gain pin passes two flops before use
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] syn;
  dsfb_flags_t fl;

  assign raw = {GAIN_PROGRAMMED_I, GAIN_APPLIED_I, HP_OC_I, CONV_OVF_I, HP_PWR_I, CONV_PWR_I};

  dsfb_sync #(.W(SYNC_W)) u_sync (
    .clk_i(REF_CLK_I),
    .rst_b_i(RST_B_I),
    .d_i(raw),
    .q_o(syn)
  );

  // Gain comparison on synchronised words; a transient mismatch only drops the flag
  always_comb begin
    fl.conv_pwr = syn[SY_CONV];
    fl.hp_pwr = syn[SY_HP];
    fl.gain_ok = (syn[SY_GA +: GAIN_W] == syn[SY_GP +: GAIN_W]);
    fl.ovf = syn[SY_OVF];
    fl.oc = syn[SY_OC];
  end

  // Bus state
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // Flag and interrupt state
  logic ovf_st_q, ovf_st_d, oc_st_q, oc_st_d;
  logic ovf_prev_q, ovf_prev_d, oc_prev_q, oc_prev_d;
  logic [1:0] stat_q, stat_d, mask_q, mask_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic irq_q, irq_d;
  logic line_q, line_d, train_q, train_d;
  logic [CNT_W-1:0] pcnt_q, pcnt_d;
  // Combinational helpers
  logic aw_go, w_go, ar_go, wr_do, lane0;
  logic [7:0] wr_addr, rd_val;
  logic [31:0] wr_data;
  logic [IDX_W-1:0] ar_idx, wr_idx;
  logic clr_ovf, clr_oc, ev_ovf, ev_oc, line_ev, pulse_end;

  // Handshakes: a channel is ready while it has no held item and no answer is pending
  assign AXI_AWREADY_O = !aw_held_q && !bvalid_q;
  assign AXI_WREADY_O = !w_held_q && !bvalid_q;
  assign AXI_ARREADY_O = !rvalid_q;
  assign aw_go = AXI_AWVALID_I && AXI_AWREADY_O;
  assign w_go = AXI_WVALID_I && AXI_WREADY_O;
  assign ar_go = AXI_ARVALID_I && AXI_ARREADY_O;
  assign wr_addr = aw_held_q ? aw_addr_q : AXI_AWADDR_I;
  assign wr_data = w_held_q ? w_data_q : AXI_WDATA_I;
  assign lane0 = w_held_q ? w_strb_q[0] : AXI_WSTRB_I[0];
  assign wr_do = (aw_held_q || aw_go) && (w_held_q || w_go) && !bvalid_q;
  assign wr_idx = to_idx(wr_addr);
  assign ar_idx = to_idx(AXI_ARADDR_I);

  // Read-clear strobes taken at the address handshake of a sticky register
  assign clr_ovf = ar_go && reg_ok(AXI_ARADDR_I) && (ar_idx == IDX_OVF_STICKY);
  assign clr_oc = ar_go && reg_ok(AXI_ARADDR_I) && (ar_idx == IDX_OC_STICKY);
  assign ev_ovf = fl.ovf && !ovf_prev_q;
  assign ev_oc = fl.oc && !oc_prev_q;
  assign line_ev = (ev_ovf && ctrl_q[CTRL_OVF_EN]) || (ev_oc && ctrl_q[CTRL_OC_EN]);
  assign pulse_end = (pcnt_q == CNT_W'(PULSE_CYCLES - 1));

  // Read value mux; reserved bits and registers give zero
  always_comb begin
    rd_val = RST_REG8;
    if (ar_idx == IDX_CONV_PWR) begin
      rd_val[BIT_CONV_PWR] = fl.conv_pwr;
      rd_val[BIT_HP_PWR] = fl.hp_pwr;
    end else if (ar_idx == IDX_GAIN_SETTLE) begin
      rd_val[BIT_GAIN_OK] = fl.gain_ok;
    end else if (ar_idx == IDX_OVF_STICKY) begin
      rd_val[BIT_OVF] = ovf_st_q;
    end else if (ar_idx == IDX_OVF_LIVE) begin
      rd_val[BIT_OVF] = fl.ovf;
    end else if (ar_idx == IDX_OC_STICKY) begin
      rd_val[BIT_OC] = oc_st_q;
    end else if (ar_idx == IDX_OC_LIVE) begin
      rd_val[BIT_OC] = fl.oc;
    end else if (ar_idx == IDX_IRQ_STAT) begin
      rd_val[1:0] = stat_q;
    end else if (ar_idx == IDX_IRQ_MASK) begin
      rd_val[1:0] = mask_q;
    end else if (ar_idx == IDX_LINE_CTRL) begin
      rd_val = ctrl_q;
    end
  end

  // Bus next state: write address and data may arrive in either order
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q && !AXI_BREADY_I;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !AXI_RREADY_I;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (aw_go) begin
      aw_held_d = 1'b1;
      aw_addr_d = AXI_AWADDR_I;
    end
    if (w_go) begin
      w_held_d = 1'b1;
      w_data_d = AXI_WDATA_I;
      w_strb_d = AXI_WSTRB_I;
    end
    if (wr_do) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = reg_ok(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    // Unmapped reads answer an error with zero data
    if (ar_go) begin
      rvalid_d = 1'b1;
      rresp_d = reg_ok(AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
      rdata_d = reg_ok(AXI_ARADDR_I) ? {24'h000000, rd_val} : 32'h00000000;
    end
  end

  // Flag, status and line next state; setting always beats clearing
  always_comb begin
    ovf_prev_d = fl.ovf;
    oc_prev_d = fl.oc;
    ovf_st_d = fl.ovf || (ovf_st_q && !clr_ovf);
    oc_st_d = fl.oc || (oc_st_q && !clr_oc);
    stat_d = stat_q;
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    // Writes to read-only or reserved registers are accepted and dropped
    if (wr_do && reg_ok(wr_addr) && lane0) begin
      if (wr_idx == IDX_IRQ_STAT) begin
        stat_d = stat_q & ~wr_data[1:0];
      end else if (wr_idx == IDX_IRQ_MASK) begin
        mask_d = wr_data[1:0];
      end else if (wr_idx == IDX_LINE_CTRL) begin
        ctrl_d = wr_data[7:0];
      end
    end
    if (ev_ovf) begin
      stat_d[STAT_OVF] = 1'b1;
    end
    if (ev_oc) begin
      stat_d[STAT_OC] = 1'b1;
    end
    irq_d = |(stat_d & mask_d);
    // Pulse line: one pulse per event, or a high/low train until a sticky read
    line_d = line_q;
    train_d = train_q;
    pcnt_d = pcnt_q;
    if (line_ev) begin
      line_d = 1'b1;
      train_d = ctrl_q[CTRL_REPEAT];
      pcnt_d = '0;
    end else if (clr_ovf || clr_oc) begin
      line_d = 1'b0;
      train_d = 1'b0;
      pcnt_d = '0;
    end else if (line_q || train_q) begin
      pcnt_d = pulse_end ? '0 : CNT_W'(pcnt_q + 1'b1);
      if (pulse_end) begin
        line_d = train_q ? !line_q : 1'b0;
      end
    end
  end

  // Registers
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
      ovf_st_q <= 1'b0;
      oc_st_q <= 1'b0;
      ovf_prev_q <= 1'b0;
      oc_prev_q <= 1'b0;
      stat_q <= RST_STAT;
      mask_q <= RST_STAT;
      ctrl_q <= RST_REG8;
      irq_q <= 1'b0;
      line_q <= 1'b0;
      train_q <= 1'b0;
      pcnt_q <= '0;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      ovf_st_q <= ovf_st_d;
      oc_st_q <= oc_st_d;
      ovf_prev_q <= ovf_prev_d;
      oc_prev_q <= oc_prev_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
      irq_q <= irq_d;
      line_q <= line_d;
      train_q <= train_d;
      pcnt_q <= pcnt_d;
    end
  end

  // Outputs, all from flops
  assign AXI_BVALID_O = bvalid_q;
  assign AXI_BRESP_O = bresp_q;
  assign AXI_RVALID_O = rvalid_q;
  assign AXI_RRESP_O = rresp_q;
  assign AXI_RDATA_O = rdata_q;
  assign IRQ_O = irq_q;
  assign IRQ_LINE_ONE_O = line_q;

  // Checks
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  sequence s_rd(logic [IDX_W-1:0] idx);
    ar_go && (AXI_ARADDR_I[1:0] == 2'h0) && (ar_idx == idx);
  endsequence

  conv_pwr_a: assert property (s_rd(IDX_CONV_PWR) |=> AXI_RDATA_O[BIT_CONV_PWR] == $past(syn[SY_CONV]))
    else $error("converter power bit wrong");
  hp_pwr_a: assert property (s_rd(IDX_CONV_PWR) |=> AXI_RDATA_O[BIT_HP_PWR] == $past(syn[SY_HP]))
    else $error("headphone power bit wrong");
  gain_ok_a: assert property (s_rd(IDX_GAIN_SETTLE) |=>
    AXI_RDATA_O[BIT_GAIN_OK] == ($past(syn[SY_GA +: GAIN_W]) == $past(syn[SY_GP +: GAIN_W])))
    else $error("gain settle bit wrong");
  ovf_clear_a: assert property (s_rd(IDX_OVF_STICKY) ##0 !syn[SY_OVF] |=> !ovf_st_q ##0 AXI_RVALID_O)
    else $error("overflow sticky not cleared by read");
  ovf_live_a: assert property (s_rd(IDX_OVF_LIVE) |=> AXI_RDATA_O[BIT_OVF] == $past(syn[SY_OVF]))
    else $error("live overflow bit wrong");
  oc_hold_a: assert property (syn[SY_OC] ##1 (!clr_oc [*2]) |=> oc_st_q)
    else $error("over-current sticky lost");
  oc_live_a: assert property (s_rd(IDX_OC_LIVE) |=> AXI_RDATA_O[BIT_OC] == $past(syn[SY_OC]))
    else $error("live over-current bit wrong");
  rsvd_zero_a: assert property (s_rd(IDX_RSVD_B1) or s_rd(IDX_RSVD_C) |=> AXI_RDATA_O == 32'h00000000)
    else $error("reserved register not zero");
  train_stop_a: assert property ((clr_ovf || clr_oc) && !line_ev |=> !train_q && !IRQ_LINE_ONE_O)
    else $error("pulse train not stopped");
  set_wins_a: assert property (syn[SY_OVF] && clr_ovf |=> ovf_st_q)
    else $error("overflow lost on clearing read");
  // Level output must agree with the registered status and mask on every clock, with no lag
  irq_level_a: assert property (IRQ_O == |(stat_q & mask_q))
    else $error("interrupt level wrong");

endmodule : dsfb_flag_bank

// file: design/dsfb_sync.sv
// Two-stage synchroniser for a vector of independent level inputs
module dsfb_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Each bit has its own pair; the first stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= d_i[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign q_o = sync_q;

endmodule : dsfb_sync

// file: include/dsfb_pkg.sv
// Package for the status and flag register bank: map, fields, reset values, timing
package dsfb_pkg;

  // Printed offsets are register indices; the byte address is four times the index
  localparam int IDX_W = 8;
  localparam logic [IDX_W-1:0] IDX_RSVD_A0 = 8'h23;
  localparam logic [IDX_W-1:0] IDX_RSVD_A1 = 8'h24;
  localparam logic [IDX_W-1:0] IDX_CONV_PWR = 8'h25;
  localparam logic [IDX_W-1:0] IDX_GAIN_SETTLE = 8'h26;
  localparam logic [IDX_W-1:0] IDX_RSVD_B0 = 8'h27;
  localparam logic [IDX_W-1:0] IDX_RSVD_B1 = 8'h28;
  localparam logic [IDX_W-1:0] IDX_RSVD_B2 = 8'h29;
  localparam logic [IDX_W-1:0] IDX_OVF_STICKY = 8'h2A;
  localparam logic [IDX_W-1:0] IDX_OVF_LIVE = 8'h2B;
  localparam logic [IDX_W-1:0] IDX_OC_STICKY = 8'h2C;
  localparam logic [IDX_W-1:0] IDX_RSVD_C = 8'h2D;
  localparam logic [IDX_W-1:0] IDX_OC_LIVE = 8'h2E;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'h3C;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h3D;
  localparam logic [IDX_W-1:0] IDX_LINE_CTRL = 8'h3E;

  // Field positions
  localparam int BIT_CONV_PWR = 7;
  localparam int BIT_HP_PWR = 5;
  localparam int BIT_GAIN_OK = 4;
  localparam int BIT_OVF = 7;
  localparam int BIT_OC = 7;
  localparam int STAT_OVF = 0;
  localparam int STAT_OC = 1;
  localparam int CTRL_REPEAT = 0;
  localparam int CTRL_OVF_EN = 2;
  localparam int CTRL_OC_EN = 3;

  // Reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [1:0] RST_STAT = 2'h0;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Gain code width and layout of the synchronised input vector
  localparam int GAIN_W = 6;
  localparam int SY_CONV = 0;
  localparam int SY_HP = 1;
  localparam int SY_OVF = 2;
  localparam int SY_OC = 3;
  localparam int SY_GA = 4;
  localparam int SY_GP = SY_GA + GAIN_W;
  localparam int SYNC_W = SY_GP + GAIN_W;

  // Interrupt line pulse width
  localparam int PULSE_TIME_US = 2000;
  localparam int CLK_MHZ = 25;
  localparam int PULSE_CYCLES_DEF = PULSE_TIME_US * CLK_MHZ;
  localparam int CNT_W = $clog2(PULSE_CYCLES_DEF + 1);

  // Conditioned inputs as one group
  typedef struct packed {
    logic conv_pwr;
    logic hp_pwr;
    logic gain_ok;
    logic ovf;
    logic oc;
  } dsfb_flags_t;

endpackage : dsfb_pkg
